// *** logic/rtc_pkg.sv ***
// Constants, types and mode decode shared by the tag control logic
`default_nettype none
package rtc_pkg;
	localparam int CFG_W       = 12;
	localparam int ARRAY_BITS  = 128;
	localparam int WORD_W      = 32;
	localparam int CNT_W       = 8;
	localparam int GAP_W       = 16;
	// Config word layout
	localparam int LEN_SEL_POS = 0;
	localparam int PERIOD_POS  = 1;
	localparam int ENC_POS     = 5;
	localparam int MOD_POS     = 7;
	localparam int LOCK_POS    = 11;
	localparam logic [CFG_W-2:0] CFG_RESET = 11'h000;
	// Frame lengths in bits
	localparam logic [CNT_W-1:0] LEN_SHORT = 8'h60;
	localparam logic [CNT_W-1:0] LEN_LONG  = 8'h80;
	// Bit periods in carrier cycles
	localparam logic [CNT_W-1:0] PERIOD_16_CYCLES  = 8'h10;
	localparam logic [CNT_W-1:0] PERIOD_32_CYCLES  = 8'h20;
	localparam logic [CNT_W-1:0] PERIOD_40_CYCLES  = 8'h28;
	localparam logic [CNT_W-1:0] PERIOD_50_CYCLES  = 8'h32;
	localparam logic [CNT_W-1:0] PERIOD_64_CYCLES  = 8'h40;
	localparam logic [CNT_W-1:0] PERIOD_80_CYCLES  = 8'h50;
	localparam logic [CNT_W-1:0] PERIOD_100_CYCLES = 8'h64;
	localparam logic [CNT_W-1:0] PERIOD_128_CYCLES = 8'h80;
	// FSK set lengths and their high portions
	localparam logic [3:0] FSK_HIGH_SET  = 4'ha;
	localparam logic [3:0] FSK_LOW_SET   = 4'h8;
	localparam logic [3:0] FSK_HIGH_DAMP = 4'h5;
	localparam logic [3:0] FSK_LOW_DAMP  = 4'h4;
	// Gap timeout: a least time, so rounded up
	localparam int CLK_PERIOD_NS = 25;
	localparam int GAP_TIME_NS   = 2000;
	localparam logic [GAP_W-1:0] GAP_CYCLES =
		GAP_W'((GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// APB byte offsets
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ARRAY  = 8'h10;

	typedef enum logic [1:0] {
		RTC_ENC_NRZ,
		RTC_ENC_MANCH,
		RTC_ENC_DIFF,
		RTC_ENC_INV
	} rtc_enc_t;

	typedef enum logic [1:0] {
		RTC_MOD_FSK,
		RTC_MOD_PSK_CHANGE,
		RTC_MOD_ASK,
		RTC_MOD_PSK_ONE
	} rtc_mod_t;

	typedef enum logic [2:0] {
		RTC_ST_POWERUP,
		RTC_ST_VERIFY,
		RTC_ST_PROGRAM,
		RTC_ST_RESPONSE,
		RTC_ST_READ
	} rtc_state_t;

	typedef struct packed {
		rtc_mod_t             modulation;
		rtc_enc_t             encoding;
		logic [CNT_W-1:0]     period;
		logic [CNT_W-1:0]     length;
	} rtc_mode_t;

	typedef struct packed {
		logic [19:0]          zero;
		logic [CNT_W-1:0]     bit_index;
		rtc_state_t           phase;
		logic                 field_on;
	} rtc_status_t;

	function automatic logic [CNT_W-1:0] rtc_period(input logic [2:0] code);
		logic [CNT_W-1:0] p;
		p = PERIOD_128_CYCLES;
		unique case (code)
			3'h0: p = PERIOD_128_CYCLES;
			3'h1: p = PERIOD_100_CYCLES;
			3'h2: p = PERIOD_80_CYCLES;
			3'h3: p = PERIOD_64_CYCLES;
			3'h4: p = PERIOD_40_CYCLES;
			3'h5: p = PERIOD_50_CYCLES;
			3'h6: p = PERIOD_32_CYCLES;
			3'h7: p = PERIOD_16_CYCLES;
		endcase
		return p;
	endfunction : rtc_period
endpackage : rtc_pkg
`default_nettype wire

// *** logic/rtc_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rtc_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	// Asynchronous in, synchronous out
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} rtc_sync_t;

	rtc_sync_t sync_reg;
	rtc_sync_t sync_next;

	always_comb begin
		sync_next.stage1 = async_i;
		sync_next.stage2 = sync_reg.stage1;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg.stage2;
endmodule : rtc_sync
`default_nettype wire

// *** logic/rtc_tag_ctl.sv ***
// Tag control: mode decode, array serialiser, contactless programming, APB
`timescale 1ns/1ps
`default_nettype none
module rtc_tag_ctl (
	// Clock and power-on reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Field side
	input  wire logic        carrier_clk_i,
	input  wire logic        field_high_i,
	output logic             modulation_o,
	output logic             locked_o,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	typedef struct packed {
		rtc_pkg::rtc_state_t                 phase;
		logic [rtc_pkg::CFG_W-2:0]           cfg;
		logic                                lock;
		logic [rtc_pkg::ARRAY_BITS-1:0]      mem;
		logic [rtc_pkg::GAP_W-1:0]           gap_cnt;
		logic                                field_on;
		logic                                car_d;
		logic [rtc_pkg::CNT_W-1:0]           cyc_cnt;
		logic [rtc_pkg::CNT_W-1:0]           bit_idx;
		logic                                lvl;
		logic [3:0]                          fsk_cnt;
		logic                                sub;
		logic                                phase_inv;
		logic                                mod;
		logic [rtc_pkg::WORD_W-1:0]          rdata;
		logic                                slverr;
	} rtc_st_t;

	rtc_st_t state_reg;
	rtc_st_t state_next;

	logic [1:0] pins_sync;
	logic       car_sync;
	logic       field_high_sync;

	rtc_sync #(
		.W (2)
	) u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i ({field_high_i, carrier_clk_i}),
		.sync_o  (pins_sync)
	);

	assign car_sync        = pins_sync[0];
	assign field_high_sync = pins_sync[1];

	rtc_pkg::rtc_mode_t  mode;
	rtc_pkg::rtc_status_t status;
	logic                car_rise;
	logic                gap_pulse;
	logic                bit_start;
	logic                bit_half;
	logic                bit_end;
	logic                frame_end;
	logic                data_bit;
	logic                enc_new;
	logic [3:0]          set_len;
	logic [3:0]          set_damp;
	logic                apb_setup;
	logic                apb_access;
	logic                addr_array;
	logic [1:0]          word_sel;

	// Mode decode: native defaults until the lock bit is set
	always_comb begin
		if (state_reg.lock) begin
			mode.modulation = rtc_pkg::rtc_mod_t'(
				state_reg.cfg[rtc_pkg::MOD_POS +: 2]);
			mode.encoding   = rtc_pkg::rtc_enc_t'(
				state_reg.cfg[rtc_pkg::ENC_POS +: 2]);
			mode.period     = rtc_pkg::rtc_period(
				state_reg.cfg[rtc_pkg::PERIOD_POS +: 3]);
			mode.length     = state_reg.cfg[rtc_pkg::LEN_SEL_POS] ?
				rtc_pkg::LEN_LONG : rtc_pkg::LEN_SHORT;
		end else begin
			mode.modulation = rtc_pkg::RTC_MOD_FSK;
			mode.encoding   = rtc_pkg::RTC_ENC_NRZ;
			mode.period     = rtc_pkg::PERIOD_128_CYCLES;
			mode.length     = rtc_pkg::LEN_LONG;
		end
	end

	assign car_rise   = car_sync & ~state_reg.car_d;
	assign bit_start  = car_rise && (state_reg.cyc_cnt == '0);
	assign bit_half   = car_rise && (state_reg.cyc_cnt == (mode.period >> 1));
	assign bit_end    = car_rise && (state_reg.cyc_cnt == mode.period - 1'b1);
	assign frame_end  = bit_end && (state_reg.bit_idx == mode.length - 1'b1);
	assign apb_setup  = psel_i & ~penable_i;
	assign apb_access = psel_i & penable_i;
	assign addr_array = (paddr_i[7:4] == rtc_pkg::ADDR_ARRAY[7:4]);
	assign word_sel   = paddr_i[3:2];

	// Source bit of the stream
	always_comb begin
		unique case (state_reg.phase)
			rtc_pkg::RTC_ST_VERIFY:  data_bit = 1'b1;
			rtc_pkg::RTC_ST_PROGRAM: data_bit = 1'b0;
			default:                 data_bit = state_reg.mem[state_reg.bit_idx[6:0]];
		endcase
	end

	// Encoded level at bit start and mid-bit
	always_comb begin
		enc_new = state_reg.lvl;
		if (bit_start) begin
			unique case (mode.encoding)
				rtc_pkg::RTC_ENC_NRZ:   enc_new = data_bit;
				rtc_pkg::RTC_ENC_MANCH: enc_new = data_bit;
				rtc_pkg::RTC_ENC_INV:   enc_new = ~data_bit;
				rtc_pkg::RTC_ENC_DIFF:  enc_new = ~state_reg.lvl;
			endcase
		end else if (bit_half) begin
			unique case (mode.encoding)
				rtc_pkg::RTC_ENC_NRZ:   enc_new = state_reg.lvl;
				rtc_pkg::RTC_ENC_MANCH: enc_new = ~data_bit;
				rtc_pkg::RTC_ENC_INV:   enc_new = data_bit;
				// Mid-bit transition marks a zero
				rtc_pkg::RTC_ENC_DIFF:  enc_new = data_bit ? state_reg.lvl : ~state_reg.lvl;
			endcase
		end
	end

	assign set_len  = enc_new ? rtc_pkg::FSK_HIGH_SET : rtc_pkg::FSK_LOW_SET;
	assign set_damp = enc_new ? rtc_pkg::FSK_HIGH_DAMP : rtc_pkg::FSK_LOW_DAMP;

	always_comb begin
		status.zero      = '0;
		status.bit_index = state_reg.bit_idx;
		status.phase     = state_reg.phase;
		status.field_on  = state_reg.field_on;
	end

	// Next-state logic
	always_comb begin
		state_next       = state_reg;
		gap_pulse        = 1'b0;
		state_next.car_d = car_sync;

		// Gap detector on the sampled carrier
		if (car_rise) begin
			state_next.gap_cnt  = '0;
			state_next.field_on = 1'b1;
		end else if (state_reg.field_on) begin
			if (state_reg.gap_cnt == rtc_pkg::GAP_CYCLES - 1'b1) begin
				state_next.field_on = 1'b0;
				gap_pulse           = 1'b1;
			end else begin
				state_next.gap_cnt = state_reg.gap_cnt + 1'b1;
			end
		end

		// Bit timer and array address
		if (car_rise) begin
			state_next.lvl = enc_new;
			if (bit_end) begin
				state_next.cyc_cnt = '0;
				state_next.bit_idx = frame_end ? '0 : state_reg.bit_idx + 1'b1;
			end else begin
				state_next.cyc_cnt = state_reg.cyc_cnt + 1'b1;
			end
			// Phase reversal rules for PSK
			if (bit_start) begin
				if (mode.modulation == rtc_pkg::RTC_MOD_PSK_CHANGE &&
				    enc_new != state_reg.lvl) begin
					state_next.phase_inv = ~state_reg.phase_inv;
				end
				if (mode.modulation == rtc_pkg::RTC_MOD_PSK_ONE && enc_new) begin
					state_next.phase_inv = ~state_reg.phase_inv;
				end
			end
			// Subcarrier at half the carrier rate
			state_next.sub = ~state_reg.sub;
			if (state_reg.fsk_cnt >= set_len - 1'b1) begin
				state_next.fsk_cnt = '0;
			end else begin
				state_next.fsk_cnt = state_reg.fsk_cnt + 1'b1;
			end
			unique case (mode.modulation)
				rtc_pkg::RTC_MOD_ASK: state_next.mod = enc_new;
				rtc_pkg::RTC_MOD_FSK: state_next.mod = (state_reg.fsk_cnt < set_damp);
				default:              state_next.mod = state_reg.sub ^ state_next.phase_inv;
			endcase
			if (state_reg.phase == rtc_pkg::RTC_ST_PROGRAM) begin
				state_next.mod = 1'b0;
			end
		end
		if (!state_next.field_on) begin
			state_next.mod = 1'b0;
		end

		// Programming sequence
		unique case (state_reg.phase)
			rtc_pkg::RTC_ST_POWERUP: begin
				if (state_reg.lock) begin
					state_next.phase = rtc_pkg::RTC_ST_READ;
				end else if (gap_pulse) begin
					state_next.phase = rtc_pkg::RTC_ST_VERIFY;
				end
			end
			rtc_pkg::RTC_ST_VERIFY: begin
				if (frame_end) begin
					state_next.phase = rtc_pkg::RTC_ST_PROGRAM;
				end
			end
			rtc_pkg::RTC_ST_PROGRAM: begin
				// Raised field at mid-bit clears the addressed cell
				if (bit_half && field_high_sync) begin
					state_next.mem[state_reg.bit_idx[6:0]] = 1'b0;
				end
				if (gap_pulse) begin
					state_next.lock  = 1'b1;
					state_next.phase = rtc_pkg::RTC_ST_READ;
				end else if (frame_end) begin
					state_next.phase = rtc_pkg::RTC_ST_RESPONSE;
				end
			end
			rtc_pkg::RTC_ST_RESPONSE: begin
				if (gap_pulse) begin
					state_next.lock  = 1'b1;
					state_next.phase = rtc_pkg::RTC_ST_READ;
				end else if (frame_end) begin
					state_next.phase = rtc_pkg::RTC_ST_PROGRAM;
				end
			end
			rtc_pkg::RTC_ST_READ: begin
				state_next.phase = rtc_pkg::RTC_ST_READ;
			end
		endcase

		// Every gap restarts the frame from its first bit
		if (gap_pulse) begin
			state_next.cyc_cnt = '0;
			state_next.bit_idx = '0;
			state_next.fsk_cnt = '0;
		end

		// APB: read data and error are prepared in the setup cycle
		if (apb_setup) begin
			state_next.rdata  = '0;
			state_next.slverr = 1'b0;
			if (paddr_i == rtc_pkg::ADDR_CONFIG) begin
				state_next.rdata = rtc_pkg::WORD_W'({state_reg.lock, state_reg.cfg});
				state_next.slverr = pwrite_i & state_reg.lock;
			end else if (paddr_i == rtc_pkg::ADDR_STATUS) begin
				state_next.rdata = status;
			end else if (addr_array && paddr_i[1:0] == 2'h0) begin
				state_next.rdata  = state_reg.mem[{word_sel, 5'h00} +: rtc_pkg::WORD_W];
				// Contact writes are refused once locked
				state_next.slverr = pwrite_i & state_reg.lock;
			end else begin
				state_next.slverr = 1'b1;
			end
		end

		// Writes land on the access edge; hardware lock set has priority
		if (apb_access && pwrite_i && !state_reg.slverr) begin
			if (paddr_i == rtc_pkg::ADDR_CONFIG) begin
				state_next.cfg  = pwdata_i[rtc_pkg::CFG_W-2:0];
				state_next.lock = state_next.lock | pwdata_i[rtc_pkg::LOCK_POS];
			end else if (addr_array) begin
				state_next.mem[{word_sel, 5'h00} +: rtc_pkg::WORD_W] = pwdata_i;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg           <= '0;
			state_reg.phase     <= rtc_pkg::RTC_ST_POWERUP;
			state_reg.cfg       <= rtc_pkg::CFG_RESET;
			state_reg.mem       <= '1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign modulation_o = state_reg.mod;
	assign locked_o     = state_reg.lock;
	assign prdata_o     = state_reg.rdata;
	assign pready_o     = apb_access;
	assign pslverr_o    = apb_access & state_reg.slverr;
endmodule : rtc_tag_ctl
`default_nettype wire

// *** bench/rtc_reader.sv ***
// Reader model: carrier clock and raised field level towards the tag
`timescale 1ns/1ps
`default_nettype none
module rtc_reader (
	// Field control from the bench
	input  wire logic field_on_i,
	input  wire logic raise_i,
	// Field towards the tag
	output logic      carrier_clk_o,
	output logic      field_high_o
);
	// Odd offset keeps carrier edges clear of system clock edges
	initial begin
		carrier_clk_o = 1'b0;
		#7;
		forever begin
			#100;
			carrier_clk_o = field_on_i ? ~carrier_clk_o : 1'b0;
		end
	end
	// No field means no raised amplitude either
	assign field_high_o = field_on_i & raise_i;
endmodule : rtc_reader
`default_nettype wire

// *** bench/rtc_tag_ctl_sva.sv ***
// Port checks for the tag control block
`timescale 1ns/1ps
`default_nettype none
module rtc_tag_ctl_sva (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_i,
	// Field side
	input wire logic        carrier_clk_i,
	input wire logic        field_high_i,
	input wire logic        modulation_o,
	input wire logic        locked_o,
	// APB
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic       car_q;
	logic [7:0] rise_q;
	logic [7:0] quiet_q;
	logic       acc_w;
	assign acc_w = psel_i && penable_i && pwrite_i;
	// Quiet count saturates so a long gap never wraps to zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			car_q   <= 1'b0;
			rise_q  <= 8'h00;
			quiet_q <= 8'h00;
		end else begin
			car_q   <= carrier_clk_i;
			rise_q  <= {rise_q[6:0], carrier_clk_i & ~car_q};
			quiet_q <= (carrier_clk_i != car_q) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
		end
	end
	property p_lock_keep; !$fell(locked_o); endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock cleared");
	property p_lock_set; acc_w && paddr_i == 8'h00 && pwdata_i[11] |-> ##[1:2] locked_o; endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not set");
	property p_cfg_refuse; acc_w && locked_o && paddr_i == 8'h00 |-> pslverr_o; endproperty
	a_cfg_refuse: assert property (p_cfg_refuse) else $error("config write taken");
	property p_arr_refuse; acc_w && locked_o && paddr_i[7:4] == 4'h1 |-> pslverr_o; endproperty
	a_arr_refuse: assert property (p_arr_refuse) else $error("array write taken");
	property p_arr_open; acc_w && !locked_o && paddr_i == 8'h1c |-> !pslverr_o; endproperty
	a_arr_open: assert property (p_arr_open) else $error("open write refused");
	property p_err_acc; pslverr_o |-> psel_i && penable_i; endproperty
	a_err_acc: assert property (p_err_acc) else $error("stray error");
	property p_mod_rise; $rose(modulation_o) |-> |rise_q; endproperty
	a_mod_rise: assert property (p_mod_rise) else $error("output without carrier");
	property p_gap_quiet; quiet_q > 8'h64 |-> !modulation_o; endproperty
	a_gap_quiet: assert property (p_gap_quiet) else $error("output in gap");
	c_lock: cover property (acc_w && paddr_i == 8'h00 && pwdata_i[11]);
	c_gap: cover property (quiet_q == 8'h80);
	c_mod: cover property ($rose(modulation_o));
endmodule : rtc_tag_ctl_sva
bind rtc_tag_ctl rtc_tag_ctl_sva u_rtc_tag_ctl_sva (.*);
`default_nettype wire

// *** bench/rtc_tag_ctl_tb.sv ***
// Self-checking bench for the tag control block
`timescale 1ns/1ps
`default_nettype none
module rtc_tag_ctl_tb;
	logic        clock_i, rst_i, carrier_clk_i, field_high_i, modulation_o, locked_o;
	logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, field_on, raise, e;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	int          bad_count, n_tests, cyc, n;
	rtc_tag_ctl u_rtc_tag_ctl (.*);
	rtc_reader u_rtc_reader (
		.field_on_i   (field_on),
		.raise_i      (raise),
		.carrier_clk_o(carrier_clk_i),
		.field_high_o (field_high_i)
	);
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) cyc <= cyc + 1;
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task tmo;
		chk("wait limit", 32'h1, 32'h0);
		give_verdict();
	endtask : tmo
	// Idle cycle after each transfer keeps psel from being driven twice at one edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		i = 0;
		do begin
			@(posedge clock_i);
			i++;
		end while (pready_o !== 1'b1 && i < 16);
		if (i >= 16) tmo();
		q = prdata_o;
		e = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask : apb
	task idx(output logic [7:0] v);
		apb(1'b0, 8'h04, 32'h0);
		v = q[11:4];
	endtask : idx
	// Poll jitter stays under half a carrier cycle, so rounding gives whole cycles
	task meas(output int r);
		logic [7:0] a, b;
		int t0, i;
		i = 0;
		idx(a);
		do begin idx(b); i++; end while (b == a && i < 2000);
		t0 = cyc;
		a = b;
		do begin idx(b); i++; end while (b == a && i < 4000);
		if (i >= 4000) tmo();
		r = (cyc - t0 + 4) / 8;
	endtask : meas
	task car_rise;
		int i;
		logic p;
		i = 0;
		do begin p = carrier_clk_i; @(posedge clock_i); i++; end
		while (!(carrier_clk_i && !p) && i < 20);
		if (i >= 20) tmo();
	endtask : car_rise
	task do_reset;
		rst_i    <= 1'b1;
		field_on <= 1'b0;
		raise    <= 1'b0;
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
	endtask : do_reset
	task power_gap;
		field_on <= 1'b1;
		repeat (160) @(posedge clock_i);
		field_on <= 1'b0;
		repeat (150) @(posedge clock_i);
		field_on <= 1'b1;
		repeat (40) @(posedge clock_i);
	endtask : power_gap
	task t_reset;
		int k;
		chk("lock", 32'(locked_o), 32'h0);
		for (k = 0; k < 4; k++) begin
			apb(1'b0, 8'(8'h10 + 4 * k), 32'h0);
			chk("blank word", q, 32'hffff_ffff);
		end
		apb(1'b0, 8'h00, 32'h0);
		chk("config", q, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped err", 32'(e), 32'h1);
		apb(1'b0, 8'h01, 32'h0);
		chk("misaligned err", 32'(e), 32'h1);
		$display("test reset done");
	endtask : t_reset
	task t_blank;
		logic [39:0] s;
		int i, bad;
		apb(1'b1, 8'h00, 32'h00a);
		power_gap();
		apb(1'b0, 8'h04, 32'h0);
		chk("phase", 32'(q[3:1]), 32'h1);
		meas(n);
		chk("native period", 32'(n), 32'h80);
		for (i = 0; i < 40; i++) begin
			car_rise();
			repeat (6) @(posedge clock_i);
			s[i] = modulation_o;
		end
		bad = 0;
		for (i = 0; i < 30; i++) bad += int'(s[i + 10] !== s[i]);
		chk("set length", 32'(bad), 32'h0);
		chk("damped cycles", 32'($countones(s)), 32'h14);
		field_on <= 1'b0;
		repeat (150) @(posedge clock_i);
		chk("lock after verify gap", 32'(locked_o), 32'h0);
		$display("test blank done");
	endtask : t_blank
	task t_locked(input logic [11:0] cfg, input int per, input int len);
		logic [7:0] b, last;
		int i;
		do_reset();
		apb(1'b1, 8'h1c, 32'h1234_5678);
		chk("open write err", 32'(e), 32'h0);
		// Short data written twice, to words 0 and 2, repeats 64 bits apart
		apb(1'b1, 8'h10, 32'h5a5a_0f0f);
		apb(1'b1, 8'h18, 32'h5a5a_0f0f);
		apb(1'b1, 8'h00, {20'h0, 1'b1, cfg[10:0]});
		chk("lock", 32'(locked_o), 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk("config", q, {20'h0, 1'b1, cfg[10:0]});
		apb(1'b1, 8'h1c, 32'h0);
		chk("closed write err", 32'(e), 32'h1);
		apb(1'b1, 8'h00, 32'h0);
		chk("config write err", 32'(e), 32'h1);
		chk("lock kept", 32'(locked_o), 32'h1);
		power_gap();
		raise <= 1'b1;
		meas(n);
		chk("bit period", 32'(n), 32'(per));
		raise <= 1'b0;
		apb(1'b0, 8'h1c, 32'h0);
		chk("array kept", q, 32'h1234_5678);
		apb(1'b0, 8'h10, 32'h0);
		chk("first copy", q, 32'h5a5a_0f0f);
		apb(1'b0, 8'h18, 32'h0);
		chk("second copy", q, 32'h5a5a_0f0f);
		if (len > 0) begin
			last = 8'h00;
			for (i = 0; i < 20000; i++) begin
				idx(b);
				if (b < last) break;
				last = b;
			end
			chk("frame length", 32'(last) + 32'h1, 32'(len));
		end
		$display("test locked %h done", cfg);
	endtask : t_locked
	initial begin
		rst_i = 1'b1;
		{psel_i, penable_i, pwrite_i, field_on, raise} = 5'h00;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		{bad_count, n_tests, cyc} = {32'h0, 32'h0, 32'h0};
		do_reset();
		t_reset();
		t_blank();
		t_locked(12'h08d, 32, 128);
		t_locked(12'h00a, 50, 96);
		t_locked(12'h14d, 32, 0);
		give_verdict();
	end
endmodule : rtc_tag_ctl_tb
`default_nettype wire
